// *** common/usb_ring_pkg.sv ***
package usb_ring_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_GEN_STATUS_ONE = 32'h10001010;
  localparam logic [31:0] OFS_INT_MASK       = 32'h10001014;
  localparam logic [31:0] OFS_GEN_STATUS_TWO = 32'h10001018;
  localparam logic [31:0] OFS_COMMAND        = 32'h10001040;
  localparam logic [31:0] OFS_COMMAND_ADDR   = 32'h10001044;
  // Index 0..2 is receive pool 0..2
  localparam logic [31:0] OFS_POOL_INFO [3] =
    '{32'h10001050, 32'h10001058, 32'h10001060};
  localparam logic [31:0] OFS_POOL_ADDR [3] =
    '{32'h10001054, 32'h1000105c, 32'h10001064};
  // Index 0 is the transmit mailbox, 1 the receive mailbox
  localparam logic [31:0] OFS_MB_START [2] =
    '{32'h10001070, 32'h10001080};
  localparam logic [31:0] OFS_MB_BOTTOM [2] =
    '{32'h10001074, 32'h10001084};
  localparam logic [31:0] OFS_MB_READ [2] =
    '{32'h10001078, 32'h10001088};
  localparam logic [31:0] OFS_MB_WRITE [2] =
    '{32'h1000107c, 32'h1000108c};

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int       ALERT_LSB      = 28;
  localparam int       ALERT_W        = 3;
  localparam int       COUNT_W        = 16;
  localparam int       CMD_BUSY_BIT   = 31;
  localparam int       CMD_CODE_LSB   = 24;
  localparam logic     CMD_POOL_MSB   = 1'b1;
  localparam int       GS1_ALERT_LSB  = 0;
  localparam int       GS1_FULL_LSB   = 3;
  localparam int       GS1_FIN_LSB    = 8;
  localparam int       GS1_FIN_STRIDE = 8;
  localparam int       GS2_BUS_RESET  = 0;
  localparam logic [31:0] RST_WORD    = 32'h0;
  localparam logic [15:0] RST_COUNT   = 16'h0;
  localparam logic [2:0]  RST_ALERT   = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  typedef struct packed {
    logic       valid;
    logic       rx;
    logic [2:0] ep;
  } ind_req_type;

endpackage

// *** hw/usb_rx_pool_mailbox_ring.sv ***
`timescale 1ns/1ps
module usb_rx_pool_mailbox_ring
  import usb_ring_pkg::*;
#(
  parameter int TX_IND_BYTES = 4,
  parameter int RX_IND_BYTES = 8
) (
  // Clock, reset, enable
  input  logic        clk_sys,
  input  logic        sys_rst,
  input  logic        clk_en,
  input  logic        warm_rst,
  // Register port
  input  reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  // Line events
  input  logic        bus_reset_seen,
  // Pool consumption by the receive engine
  input  logic [2:0]  dir_take,
  input  logic [31:0] dir_link,
  // Indication requests from the packet engines
  input  ind_req_type ind_req,
  output logic        ind_grant,
  output logic [31:0] ind_addr,
  // Interrupt request
  output logic        irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]        mb_start_q [2];
  logic [31:0]        mb_bot_q   [2];
  logic [31:0]        mb_rp_q    [2];
  logic [31:0]        mb_wp_q    [2];
  logic               mb_first_q [2];
  logic               mb_full_q  [2];
  logic [COUNT_W-1:0] pool_cnt_q [3];
  logic [ALERT_W-1:0] pool_al_q  [3];
  logic [31:0]        pool_addr_q[3];
  logic [31:0]        gs1_q;
  logic [31:0]        mask_q;
  logic               gs2_q;
  logic               busy_q;
  logic [2:0]         cmd_code_q;
  logic [COUNT_W-1:0] cmd_cnt_q;
  logic [31:0]        cmd_addr_q;
  logic [31:0]        rdata_q;
  logic               grant_q;
  logic [31:0]        iaddr_q;
  logic               irq_q;

  logic               run;
  logic               grant_d;
  logic [1:0]         adv;
  logic [1:0]         full_set;
  logic [2:0]         add;
  logic [2:0]         alert_ev;
  logic [31:0]        wp_nx [2];
  logic [31:0]        gs1_set;
  logic [31:0]        rd_d;

  // Normal operation: enabled and not under warm reset
  assign run = clk_en && !warm_rst;

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  // Writes while busy are dropped so a running command stays intact
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q     <= 1'b0;
      cmd_code_q <= RST_ALERT;
      cmd_cnt_q  <= RST_COUNT;
      cmd_addr_q <= RST_WORD;
    end else if (clk_en) begin
      if (warm_rst) begin
        busy_q     <= 1'b0;
        cmd_code_q <= RST_ALERT;
        cmd_cnt_q  <= RST_COUNT;
        cmd_addr_q <= RST_WORD;
      end else begin
        busy_q <= reg_req.wr && reg_req.addr == OFS_COMMAND && !busy_q;
        if (reg_req.wr && reg_req.addr == OFS_COMMAND && !busy_q) begin
          cmd_code_q <= reg_req.wdata[CMD_CODE_LSB +: 3];
          cmd_cnt_q  <= reg_req.wdata[COUNT_W-1:0];
        end
        if (reg_req.wr && reg_req.addr == OFS_COMMAND_ADDR && !busy_q)
          cmd_addr_q <= reg_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive pools
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_pool
    logic [COUNT_W-1:0] cnt_d;
    logic               take;

    // Code 111 never matches since p stops at two
    assign add[p] = busy_q && cmd_code_q[2] == CMD_POOL_MSB
                    && cmd_code_q[1:0] == 2'(p);
    assign take   = dir_take[p] && pool_cnt_q[p] != RST_COUNT;
    assign cnt_d  = pool_cnt_q[p] + (add[p] ? cmd_cnt_q : RST_COUNT)
                    - COUNT_W'(take);
    // Fires only on a change so a standing match flags once
    // Limitation: a count that jumps past the level raises no alert
    assign alert_ev[p] = cnt_d != pool_cnt_q[p]
                         && pool_al_q[p] != RST_ALERT
                         && cnt_d == {11'h0, pool_al_q[p], 2'h0};

    // Count, level and current directory address
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        pool_cnt_q[p]  <= RST_COUNT;
        pool_al_q[p]   <= RST_ALERT;
        pool_addr_q[p] <= RST_WORD;
      end else if (clk_en) begin
        if (warm_rst) begin
          pool_cnt_q[p]  <= RST_COUNT;
          pool_al_q[p]   <= RST_ALERT;
          pool_addr_q[p] <= RST_WORD;
        end else begin
          pool_cnt_q[p] <= cnt_d;
          if (reg_req.wr && reg_req.addr == OFS_POOL_INFO[p])
            pool_al_q[p] <= reg_req.wdata[ALERT_LSB +: ALERT_W];
          // Only commands and consumption move the address
          if (add[p] && pool_cnt_q[p] == RST_COUNT)
            pool_addr_q[p] <= cmd_addr_q;
          else if (take)
            pool_addr_q[p] <= dir_link;
        end
      end
    end

    // Software writes must not move the count or the address
    a_pool_addr_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && reg_req.wr && reg_req.addr == OFS_POOL_ADDR[p]
      && !dir_take[p] && !add[p] |=> $stable(pool_addr_q[p]))
      else $error("pool address changed by a software write");
    a_count_add_cmd: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && add[p] && !dir_take[p] |=>
      pool_cnt_q[p] == $past(pool_cnt_q[p]) + $past(cmd_cnt_q))
      else $error("pool count not raised by the added number");
    a_count_ro_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && reg_req.wr && reg_req.addr == OFS_POOL_INFO[p]
      && !add[p] && !dir_take[p] |=> $stable(pool_cnt_q[p]))
      else $error("pool count changed by a software write");
    a_alert_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && alert_ev[p] |=> gs1_q[GS1_ALERT_LSB + p])
      else $error("alert flag missing at level match");
  end

  // ----------------------------------------------------------------
  // Mailbox rings
  // ----------------------------------------------------------------
  // One grant at a time; the requester drops valid once it sees it
  // Trade-off: a grant every other cycle keeps the pointer update simple
  assign grant_d = ind_req.valid && !grant_q && !mb_full_q[ind_req.rx];

  for (genvar m = 0; m < 2; m++) begin : g_mbox
    logic [31:0] wp_inc;

    assign adv[m]   = grant_d && ind_req.rx == 1'(m);
    // An unaligned bottom is never hit, so the ring would not wrap
    assign wp_inc   = mb_wp_q[m]
                      + 32'(m == 0 ? TX_IND_BYTES : RX_IND_BYTES);
    assign wp_nx[m] = (wp_inc == mb_bot_q[m]) ? mb_start_q[m]
                                               : wp_inc;
    assign full_set[m] = adv[m] && wp_nx[m] == mb_rp_q[m];

    // Pointers, area bounds and the full state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        mb_start_q[m] <= RST_WORD;
        mb_bot_q[m]   <= RST_WORD;
        mb_rp_q[m]    <= RST_WORD;
        mb_wp_q[m]    <= RST_WORD;
        mb_first_q[m] <= 1'b1;
        mb_full_q[m]  <= 1'b0;
      end else if (clk_en) begin
        if (warm_rst) begin
          mb_start_q[m] <= RST_WORD;
          mb_bot_q[m]   <= RST_WORD;
          mb_rp_q[m]    <= RST_WORD;
          mb_wp_q[m]    <= RST_WORD;
          mb_first_q[m] <= 1'b1;
          mb_full_q[m]  <= 1'b0;
        end else begin
          // A first start write in this cycle overrides the advance
          if (adv[m])
            mb_wp_q[m] <= wp_nx[m];
          if (reg_req.wr && reg_req.addr == OFS_MB_READ[m])
            mb_rp_q[m] <= reg_req.wdata;
          if (reg_req.wr && reg_req.addr == OFS_MB_BOTTOM[m])
            mb_bot_q[m] <= reg_req.wdata;
          // The first start write seeds both pointers
          if (reg_req.wr && reg_req.addr == OFS_MB_START[m]) begin
            mb_start_q[m] <= reg_req.wdata;
            mb_first_q[m] <= 1'b0;
            if (mb_first_q[m]) begin
              mb_rp_q[m] <= reg_req.wdata;
              mb_wp_q[m] <= reg_req.wdata;
            end
          end
          // A read pointer update frees space; a new fill wins
          if (full_set[m])
            mb_full_q[m] <= 1'b1;
          else if (reg_req.wr && reg_req.addr == OFS_MB_READ[m])
            mb_full_q[m] <= 1'b0;
        end
      end
    end

    // Seeding, wrap, full hold-off and finish bits
    a_start_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && mb_first_q[m] && reg_req.wr
      && reg_req.addr == OFS_MB_START[m] |=>
      mb_rp_q[m] == $past(reg_req.wdata)
      && mb_wp_q[m] == $past(reg_req.wdata))
      else $error("first start write did not seed pointers");
    a_wp_wrap_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && adv[m] && wp_inc == mb_bot_q[m]
      && !(reg_req.wr && reg_req.addr == OFS_MB_START[m]) |=>
      mb_wp_q[m] == $past(mb_start_q[m]))
      else $error("write pointer did not wrap to start");
    a_full_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && full_set[m] |=>
      mb_full_q[m] && gs1_q[GS1_FULL_LSB + m])
      else $error("full flag missing when pointers meet");
    a_full_holds_ind: assert property (@(posedge clk_sys) disable iff (sys_rst)
      clk_en && mb_full_q[m] && ind_req.valid && ind_req.rx == 1'(m)
      |=> !grant_q)
      else $error("indication granted into a full mailbox");
    a_finish_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && adv[m] |=>
      gs1_q[GS1_FIN_LSB + m*GS1_FIN_STRIDE + $past(ind_req.ep)])
      else $error("finish flag missing after indication");
    a_rp_sw_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      run && reg_req.wr && reg_req.addr == OFS_MB_READ[m]
      |=> mb_rp_q[m] == $past(reg_req.wdata))
      else $error("read pointer did not take the written value");
  end

  // ----------------------------------------------------------------
  // Status, mask and grant
  // ----------------------------------------------------------------
  // Gather hardware events into status bit positions
  always_comb begin
    gs1_set = RST_WORD;
    gs1_set[GS1_ALERT_LSB +: 3] = alert_ev;
    gs1_set[GS1_FULL_LSB +: 2]  = full_set;
    for (int m = 0; m < 2; m++) begin
      if (adv[m])
        gs1_set[GS1_FIN_LSB + m*GS1_FIN_STRIDE + ind_req.ep] = 1'b1;
    end
  end

  // Write one to clear; an event in the same cycle still lands
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gs1_q  <= RST_WORD;
      gs2_q  <= 1'b0;
      mask_q <= RST_WORD;
    end else if (clk_en) begin
      if (warm_rst) begin
        gs1_q  <= RST_WORD;
        gs2_q  <= 1'b0;
        mask_q <= RST_WORD;
      end else begin
        if (reg_req.wr && reg_req.addr == OFS_GEN_STATUS_ONE)
          gs1_q <= (gs1_q & ~reg_req.wdata) | gs1_set;
        else
          gs1_q <= gs1_q | gs1_set;
        if (bus_reset_seen)
          gs2_q <= 1'b1;
        else if (reg_req.wr && reg_req.addr == OFS_GEN_STATUS_TWO
                 && reg_req.wdata[GS2_BUS_RESET])
          gs2_q <= 1'b0;
        if (reg_req.wr && reg_req.addr == OFS_INT_MASK)
          mask_q <= reg_req.wdata;
      end
    end
  end

  // Grant pulse, slot address and masked interrupt
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      grant_q <= 1'b0;
      iaddr_q <= RST_WORD;
      irq_q   <= 1'b0;
    end else if (clk_en) begin
      grant_q <= run && grant_d;
      if (run && grant_d)
        iaddr_q <= mb_wp_q[ind_req.rx];
      irq_q <= !warm_rst && |(gs1_q & mask_q);
    end
  end

  // Status two and the warm reset
  a_bus_reset_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    run && bus_reset_seen |=> gs2_q)
    else $error("bus reset flag not raised");
  a_warm_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_en && warm_rst |=> gs1_q == RST_WORD && mb_wp_q[0] == RST_WORD
    && pool_cnt_q[0] == RST_COUNT && !busy_q)
    else $error("warm reset left state behind");

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  // Read-only registers ignore writes simply by having no write path
  always_comb begin
    rd_d = RST_WORD;
    if (reg_req.addr == OFS_GEN_STATUS_ONE) rd_d = gs1_q;
    if (reg_req.addr == OFS_INT_MASK)       rd_d = mask_q;
    if (reg_req.addr == OFS_GEN_STATUS_TWO) rd_d = {31'h0, gs2_q};
    if (reg_req.addr == OFS_COMMAND)
      rd_d = {busy_q, 4'h0, cmd_code_q, 8'h0, cmd_cnt_q};
    if (reg_req.addr == OFS_COMMAND_ADDR)   rd_d = cmd_addr_q;
    for (int p = 0; p < 3; p++) begin
      if (reg_req.addr == OFS_POOL_INFO[p])
        rd_d = {1'b0, pool_al_q[p], 12'h0, pool_cnt_q[p]};
      if (reg_req.addr == OFS_POOL_ADDR[p])
        rd_d = pool_addr_q[p];
    end
    for (int m = 0; m < 2; m++) begin
      if (reg_req.addr == OFS_MB_START[m])  rd_d = mb_start_q[m];
      if (reg_req.addr == OFS_MB_BOTTOM[m]) rd_d = mb_bot_q[m];
      if (reg_req.addr == OFS_MB_READ[m])   rd_d = mb_rp_q[m];
      if (reg_req.addr == OFS_MB_WRITE[m])  rd_d = mb_wp_q[m];
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      rdata_q <= RST_WORD;
    else if (clk_en)
      rdata_q <= reg_req.rd ? rd_d : RST_WORD;
  end

  assign reg_rdata = rdata_q;
  assign ind_grant = grant_q;
  assign ind_addr  = iaddr_q;
  assign irq       = irq_q;

endmodule

// *** verif/ind_source.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Packet-engine side: one indication request per go pulse
// ----------------------------------------------------------------
module ind_source
  import usb_ring_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Bench control
  input  wire logic        go,
  input  wire logic        go_rx,
  input  wire logic [2:0]  go_ep,
  output logic             busy,
  output logic [31:0]      last_addr,
  // Link to the block
  input  wire logic        ind_grant,
  input  wire logic [31:0] ind_addr,
  output ind_req_type      ind_req
);
  // Request held until granted; a full mailbox may stall it for long
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ind_req   <= '0;
      last_addr <= '0;
    end else if (ind_req.valid && ind_grant) begin
      ind_req.valid <= 1'b0;
      // Released qualifiers show the inverse, never the old value
      ind_req.rx    <= ~ind_req.rx;
      ind_req.ep    <= ~ind_req.ep;
      last_addr     <= ind_addr;
    end else if (go && !ind_req.valid) begin
      ind_req <= '{valid: 1'b1, rx: go_rx, ep: go_ep};
    end
  end

  // Busy while a request is outstanding
  assign busy = ind_req.valid;
endmodule

// *** verif/usb_rx_pool_mailbox_ring_bench.sv ***
`timescale 1ns/1ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin \
  n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, act, \
  exp); end end
// ----------------------------------------------------------------
// Register-level bench for pools and indication mailboxes
// ----------------------------------------------------------------
module usb_rx_pool_mailbox_ring_bench
  import usb_ring_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        warm_rst = 1'b0;
  logic        bus_reset_seen = 1'b0;
  logic [2:0]  dir_take = 3'h0;
  logic [31:0] dir_link = 32'h0;
  logic        go = 1'b0;
  logic        go_rx = 1'b0;
  logic [2:0]  go_ep = 3'h0;
  reg_req_type req = '0;
  ind_req_type ind_req;
  logic [31:0] rdata;
  logic [31:0] ind_addr;
  logic [31:0] last_addr;
  logic        ind_grant;
  logic        irq;
  logic        busy;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [2:0]  lvl [3] = '{3'h1, 3'h0, 3'h2};
  logic [15:0] cnt [3] = '{16'h4, 16'h8, 16'h8};

  always #5 clk_sys = ~clk_sys;

  usb_rx_pool_mailbox_ring #(.TX_IND_BYTES(4), .RX_IND_BYTES(8)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .warm_rst(warm_rst), .reg_req(req), .reg_rdata(rdata),
    .bus_reset_seen(bus_reset_seen), .dir_take(dir_take),
    .dir_link(dir_link), .ind_req(ind_req), .ind_grant(ind_grant),
    .ind_addr(ind_addr), .irq(irq));

  ind_source u_src (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .go_rx(go_rx),
    .go_ep(go_ep), .busy(busy), .last_addr(last_addr),
    .ind_grant(ind_grant), .ind_addr(ind_addr), .ind_req(ind_req));

  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Bounded wait until the outstanding request is granted
  task automatic wait_idle();
    int i;
    i = 0;
    #1;
    while (busy && i < 20) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    `CHK(busy, 1'b0)
  endtask

  task automatic ind(input logic rx, input logic [2:0] ep,
                     input logic [31:0] e);
    @(posedge clk_sys);
    go    <= 1'b1;
    go_rx <= rx;
    go_ep <= ep;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(ind_grant, 1'b1)
    wait_idle();
    `CHK(last_addr, e)
    `CHK(ind_grant, 1'b0)
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      rd(OFS_MB_READ[m], 32'h0);
      rd(OFS_MB_WRITE[m], 32'h0);
    end
    // Pools: count bits and address are not writable by software
    for (int p = 0; p < 3; p++) begin
      wr(OFS_POOL_INFO[p], {1'b0, lvl[p], 12'h0, 16'hffff});
      wr(OFS_POOL_ADDR[p], 32'hdead0000);
      rd(OFS_POOL_INFO[p], {1'b0, lvl[p], 12'h0, 16'h0});
      rd(OFS_POOL_ADDR[p], 32'h0);
      wr(OFS_COMMAND_ADDR, 32'h2000 + 32'(p) * 32'h100);
      wr(OFS_COMMAND, {5'h0, 3'h4 + 3'(p), 8'h0, cnt[p]});
      repeat (2) @(posedge clk_sys);
      rd(OFS_POOL_INFO[p], {1'b0, lvl[p], 12'h0, cnt[p]});
      rd(OFS_POOL_ADDR[p], 32'h2000 + 32'(p) * 32'h100);
    end
    // Reserved code 111 is latched with its count and sets busy; no pool moves
    wr(OFS_COMMAND, 32'h07000004);
    rd(OFS_POOL_INFO[1], 32'h00000008);
    rd(OFS_COMMAND, 32'h07000004);
    @(posedge clk_sys);
    dir_take <= 3'h1;
    dir_link <= 32'h5000;
    @(posedge clk_sys);
    dir_take <= 3'h0;
    rd(OFS_POOL_INFO[0], 32'h10000003);
    rd(OFS_POOL_ADDR[0], 32'h5000);
    // Transmit ring of three slots; only the first start write copies
    wr(OFS_MB_START[0], 32'h100);
    wr(OFS_MB_BOTTOM[0], 32'h10c);
    rd(OFS_MB_READ[0], 32'h100);
    rd(OFS_MB_WRITE[0], 32'h100);
    wr(OFS_MB_READ[0], 32'h108);
    wr(OFS_MB_START[0], 32'h100);
    wr(OFS_MB_WRITE[0], 32'h0);
    rd(OFS_MB_READ[0], 32'h108);
    rd(OFS_MB_WRITE[0], 32'h100);
    ind(1'b0, 3'h1, 32'h100);
    ind(1'b0, 3'h1, 32'h104);
    rd(OFS_MB_WRITE[0], 32'h108);
    rd(OFS_GEN_STATUS_ONE, 32'h20d);
    // Full ring must stall the next request
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    `CHK(busy, 1'b1)
    wr(OFS_INT_MASK, 32'h8);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(irq, 1'b1)
    wr(OFS_MB_READ[0], 32'h100);
    wait_idle();
    `CHK(last_addr, 32'h108)
    rd(OFS_MB_WRITE[0], 32'h100);
    wr(OFS_GEN_STATUS_ONE, 32'h8);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(irq, 1'b0)
    // Receive ring of two eight-byte slots
    wr(OFS_MB_START[1], 32'h400);
    wr(OFS_MB_BOTTOM[1], 32'h410);
    ind(1'b1, 3'h2, 32'h400);
    ind(1'b1, 3'h2, 32'h408);
    rd(OFS_MB_WRITE[1], 32'h400);
    rd(OFS_GEN_STATUS_ONE, 32'h40215);
    @(posedge clk_sys);
    #1;
    `CHK(rdata, 32'h0)
    rd(32'h10001100, 32'h0);
    // Host reset signalling, then the warm reset that follows it
    @(posedge clk_sys);
    bus_reset_seen <= 1'b1;
    @(posedge clk_sys);
    bus_reset_seen <= 1'b0;
    rd(OFS_GEN_STATUS_TWO, 32'h1);
    wr(OFS_GEN_STATUS_TWO, 32'h1);
    rd(OFS_GEN_STATUS_TWO, 32'h0);
    @(posedge clk_sys);
    warm_rst <= 1'b1;
    @(posedge clk_sys);
    warm_rst <= 1'b0;
    // A take on an empty pool is ignored
    dir_take <= 3'h4;
    dir_link <= 32'h7000;
    @(posedge clk_sys);
    dir_take <= 3'h0;
    rd(OFS_MB_START[0], 32'h0);
    rd(OFS_MB_WRITE[1], 32'h0);
    rd(OFS_POOL_INFO[0], 32'h0);
    rd(OFS_POOL_ADDR[2], 32'h0);
    rd(OFS_POOL_INFO[2], 32'h0);
    rd(OFS_GEN_STATUS_ONE, 32'h0);
    wr(OFS_MB_START[0], 32'h300);
    rd(OFS_MB_WRITE[0], 32'h300);
    // A write with the clock enable low is lost
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(OFS_MB_BOTTOM[1], 32'h55);
    clk_en <= 1'b1;
    rd(OFS_MB_BOTTOM[1], 32'h0);
    test_done();
  end
endmodule
